// ### include/asr_defs.svh
// Constants of the angle sensor serial readout block
`ifndef ASR_DEFS_SVH
`define ASR_DEFS_SVH

// Timing
`define ASR_CLK_HZ        25_000_000
`define ASR_SAMPLE_NS     1000
`define ASR_SAMPLE_CYC    ((`ASR_SAMPLE_NS * (`ASR_CLK_HZ / 1_000_000)) / 1000)
`define ASR_SCLK_MAX_HZ   25_000_000

// Frame layout
`define ASR_FRAME_BITS    16
`define ASR_CMD_MSB       15
`define ASR_CMD_LSB       13
`define ASR_ADDR_MSB      12
`define ASR_ADDR_LSB      8
`define ASR_DATA_MSB      7
`define ASR_DATA_LSB      0
`define ASR_CMD_READ      3'h2
`define ASR_CMD_WRITE     3'h4

// Configuration registers
`define ASR_REG_COUNT     32
`define ASR_REG_ZERO_LO   5'h00
`define ASR_REG_ZERO_HI   5'h01
`define ASR_REG_DIR       5'h09
`define ASR_DIR_BIT       7
`define ASR_REG_FILTER    5'h0E
`define ASR_FILTER_DEF    8'h04
`define ASR_REG_DEF       8'h00

`endif

// ### include/asr_pkg.sv
// Types of the angle sensor serial readout block
package asr_pkg;

  typedef enum logic [1:0] {
    ASR_KIND_ANGLE,
    ASR_KIND_READ,
    ASR_KIND_WRITE
  } asr_kind_t;

  typedef enum logic [1:0] {
    ASR_RPL_NONE,
    ASR_RPL_ARMED,
    ASR_RPL_SENDING
  } asr_reply_t;

endpackage : asr_pkg

// ### hdl/asr_sync.sv
// Two flip-flop level synchroniser
`timescale 1ns/100ps
`default_nettype none

module asr_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst_b,
  // Level in and out
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_reg;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      meta_reg <= '0;
      q        <= '0;
    end else begin
      meta_reg <= d;
      q        <= meta_reg;
    end
  end

endmodule : asr_sync

`default_nettype wire

// ### hdl/asr_filter.sv
// Second-order angle smoothing loop
`timescale 1ns/100ps
`default_nettype none

module asr_filter #(
  parameter int W    = 16,
  parameter int FRAC = 16
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst_b,
  // Raw samples
  input  wire logic         in_valid,
  input  wire logic [W-1:0] in_angle,
  input  wire logic [3:0]   in_shift,
  // Smoothed angle
  output logic      [W-1:0] out_angle
);

  localparam int A = W + FRAC;

  logic        [A-1:0] y_reg;
  logic signed [A-1:0] v_reg;
  logic                primed_reg;

  // Tau is 2^k samples; cutoff = 0.38 / tau
  wire         [3:0]   k      = (in_shift == 4'h0) ? 4'h1 :
                                (in_shift > 4'hC)  ? 4'hC : in_shift;
  wire         [W-1:0] e_wrap = in_angle - y_reg[A-1 -: W];
  wire signed  [A-1:0] err_w  = signed'({e_wrap, {FRAC{1'b0}}});
  // Velocity term keeps zero lag at constant speed
  wire signed  [A-1:0] v_next = v_reg + (err_w >>> (2 * k));                  // [R02] [R03]
  wire         [A-1:0] y_next = y_reg + A'(v_next) + A'(err_w >>> (k - 4'h1)); // [R02]

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      y_reg      <= '0;
      v_reg      <= '0;
      primed_reg <= 1'b0;
    end else if (in_valid) begin
      // First sample seeds the loop to avoid a start-up slew
      if (!primed_reg) begin
        y_reg      <= {in_angle, {FRAC{1'b0}}};
        v_reg      <= '0;
        primed_reg <= 1'b1;
      end else begin
        y_reg      <= y_next;
        v_reg      <= v_next;
      end
    end
  end

  assign out_angle = y_reg[A-1 -: W];

endmodule : asr_filter

`default_nettype wire

// ### hdl/asr_readout.sv
// Angle sensor serial readout: sampling, smoothing, buffer and four-wire slave
`include "asr_defs.svh"
`timescale 1ns/100ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// How it works
// [R01] A new raw angle is taken from the front-end every microsecond.
// [R02] Raw angle is smoothed by a second-order loop, tau from cutoff setting.
// [R03] Smoothing adds no lag once the input is steady.
// [R04] Angle rises clockwise by default; direction and zero are programmable.
// [R05] Slave works in clock-idle-low and clock-idle-high without configuration.
// [R06] Serial clock up to 25 MHz, with no lower limit.
// [R07] Input sampled on rising clock edge, output changed on falling edge.
// [R08] Host sends every command as a frame of exactly 16 bits.
// [R09] Three kinds of frames: angle read, register read, register write.
// [R10] Host keeps select high at least 150 ns between angle reads.
// [R11] Host keeps select high at least 750 ns around a register readout.
// [R12] Host waits 20 ms after a write before reading back.
// [R13] Buffer reloads with the filtered angle every microsecond when not held.
// [R14] Select falling freezes the buffer; select rising releases it.
// [R15] Angle read is 16 clocks, MSB first, host input held at zero.
// [R16] Bits below the useful resolution are sent as zeros.
// [R17] Reads cut short after fewer clocks are accepted without error.
// [R18] Fast repeated reads return the same angle until the next reload.
// [R19] Register access only over the four-wire slave; other link is angle-only.
// [R20] Read request is code 010, 5-bit address, eight zeros; next frame replies.
// [R21] Write request is code 100, address, value; next frame echoes the value.
// [R22] Select high idles the output, aborts partial frames, restarts bit count.
// [R23] All frame bits shift most significant bit first.
module asr_readout
  import asr_pkg::*;
#(
  parameter int ANGLE_BITS = 14,
  parameter int FRAC_BITS  = 16
) (
  // System clock and reset
  input  wire logic        clk,
  input  wire logic        rst_b,
  // Front-end angle code
  input  wire logic [15:0] fe_angle,
  // Four-wire serial link
  input  wire logic        spi_sclk,
  input  wire logic        spi_cs_b,
  input  wire logic        spi_mosi,
  output logic             spi_miso,
  output logic             spi_miso_oe_b,
  // Smoothed angle for on-chip users
  output logic [15:0]      angle_out,
  output logic             angle_tick
);

  localparam int          FB       = `ASR_FRAME_BITS;
  localparam int          SAMPLE_C = `ASR_SAMPLE_CYC;
  localparam logic [15:0] PAD_MASK = 16'hFFFF << (16 - ANGLE_BITS);

  //////////////////////////////////////////////////////////////////////////////
  // Sample tick

  logic [4:0] tick_cnt_reg;
  wire        tick_now = (tick_cnt_reg == 5'(SAMPLE_C - 1));

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      tick_cnt_reg <= 5'h00;
    end else begin
      tick_cnt_reg <= tick_now ? 5'h00 : tick_cnt_reg + 5'h01; // [R01] [R13]
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Front-end sampling and smoothing

  logic [15:0] fe_sample_reg;
  logic        fe_valid_reg;
  logic [15:0] smooth_w;
  logic [7:0]  cfg_reg [`ASR_REG_COUNT];

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      fe_sample_reg <= 16'h0000;
      fe_valid_reg  <= 1'b0;
    end else begin
      fe_valid_reg  <= tick_now;
      if (tick_now) begin
        fe_sample_reg <= fe_angle; // [R01]
      end
    end
  end

  asr_filter #(
    .W    (16),
    .FRAC (FRAC_BITS)
  ) u_filter (
    .clk       (clk),
    .rst_b     (rst_b),
    .in_valid  (fe_valid_reg),
    .in_angle  (fe_sample_reg),
    .in_shift  (cfg_reg[`ASR_REG_FILTER][3:0]),
    .out_angle (smooth_w)
  );

  // Zero offset and counting direction
  wire [15:0] zero_w    = {cfg_reg[`ASR_REG_ZERO_HI], cfg_reg[`ASR_REG_ZERO_LO]};
  wire        ccw_w     = cfg_reg[`ASR_REG_DIR][`ASR_DIR_BIT];
  wire [15:0] rel_w     = smooth_w - zero_w;                       // [R04]
  wire [15:0] dir_w     = ccw_w ? 16'h0000 - rel_w : rel_w;        // [R04]
  wire [15:0] padded_w  = dir_w & PAD_MASK;                        // [R16]

  //////////////////////////////////////////////////////////////////////////////
  // Link clock domain: select acts as the frame reset

  wire        link_rst_b = rst_b & ~spi_cs_b;                      // [R22]
  logic [4:0] rx_cnt_reg;
  logic [14:0] rx_shift_reg;
  logic        seen_rise_reg;
  logic [4:0]  tx_idx_reg;
  logic [15:0] cmd_word_reg;
  logic        cmd_tgl_reg;
  logic [15:0] tx_word_w;

  wire         rx_last = (rx_cnt_reg == 5'(FB - 1));

  // Capture on rising edges, in either clock polarity
  always_ff @(posedge spi_sclk or negedge link_rst_b) begin
    if (!link_rst_b) begin
      rx_cnt_reg    <= 5'h00;                                      // [R22]
      rx_shift_reg  <= 15'h0000;
      seen_rise_reg <= 1'b0;
    end else begin
      seen_rise_reg <= 1'b1;                                       // [R05] [R07]
      if (rx_cnt_reg < 5'(FB)) begin
        rx_cnt_reg   <= rx_cnt_reg + 5'h01;                        // [R06]
        rx_shift_reg <= {rx_shift_reg[13:0], spi_mosi};            // [R23] [R07]
      end
    end
  end

  // A whole 16-bit frame is handed over; partial ones are dropped
  always_ff @(posedge spi_sclk or negedge rst_b) begin
    if (!rst_b) begin
      cmd_word_reg <= 16'h0000;
      cmd_tgl_reg  <= 1'b0;
    end else if (!spi_cs_b && rx_last) begin
      cmd_word_reg <= {rx_shift_reg, spi_mosi};                    // [R08] [R23]
      cmd_tgl_reg  <= ~cmd_tgl_reg;
    end
  end

  // The falling edge before the first rise belongs to idle-high mode
  // and must not advance the output bit.
  always_ff @(negedge spi_sclk or negedge link_rst_b) begin
    if (!link_rst_b) begin
      tx_idx_reg <= 5'h00;                                         // [R22]
    end else if (seen_rise_reg && tx_idx_reg < 5'(FB)) begin
      tx_idx_reg <= tx_idx_reg + 5'h01;                            // [R05] [R07]
    end
  end

  // First bit is shown as select falls, before any clock edge, so the
  // output is a select from the held word rather than a flip-flop.
  wire [3:0] tx_bit_w  = 4'(FB - 1) - tx_idx_reg[3:0];
  wire       tx_done_w = tx_idx_reg[4];
  assign spi_miso      = (!spi_cs_b && !tx_done_w) ? tx_word_w[tx_bit_w] : 1'b0; // [R23] [R17]
  assign spi_miso_oe_b = spi_cs_b;                                 // [R22]

  //////////////////////////////////////////////////////////////////////////////
  // Crossings into the system clock

  logic cs_b_s;
  logic tgl_s;
  logic cs_b_prev_reg;
  logic tgl_prev_reg;

  asr_sync #(
    .W (1)
  ) u_sync_cs (
    .clk   (clk),
    .rst_b (rst_b),
    .d     (spi_cs_b),
    .q     (cs_b_s)
  );

  asr_sync #(
    .W (1)
  ) u_sync_cmd (
    .clk   (clk),
    .rst_b (rst_b),
    .d     (cmd_tgl_reg),
    .q     (tgl_s)
  );

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cs_b_prev_reg <= 1'b1;
      tgl_prev_reg  <= 1'b0;
    end else begin
      cs_b_prev_reg <= cs_b_s;
      tgl_prev_reg  <= tgl_s;
    end
  end

  wire cs_fall = cs_b_prev_reg & ~cs_b_s;
  wire cs_rise = ~cs_b_prev_reg & cs_b_s;
  wire cmd_evt = tgl_s ^ tgl_prev_reg;

  //////////////////////////////////////////////////////////////////////////////
  // Output buffer

  logic [15:0] angle_buf_reg;

  // Limitation: the hold takes effect two to three clocks after select
  // falls; a reload in that window lands before the first bit is used.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      angle_buf_reg <= 16'h0000;
    end else if (tick_now && cs_b_s) begin
      angle_buf_reg <= padded_w;                                   // [R13] [R14] [R18]
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Command decode and registers

  wire [2:0] cmd_code = cmd_word_reg[`ASR_CMD_MSB:`ASR_CMD_LSB];
  wire [4:0] cmd_addr = cmd_word_reg[`ASR_ADDR_MSB:`ASR_ADDR_LSB];
  wire [7:0] cmd_data = cmd_word_reg[`ASR_DATA_MSB:`ASR_DATA_LSB];

  // Only this four-wire path can reach the registers
  asr_kind_t kind_w;
  assign kind_w = (cmd_code == `ASR_CMD_READ)  ? ASR_KIND_READ  :   // [R09] [R19] [R20]
                  (cmd_code == `ASR_CMD_WRITE) ? ASR_KIND_WRITE :   // [R09] [R21]
                                                 ASR_KIND_ANGLE;    // [R09] [R15]

  wire do_read  = cmd_evt && (kind_w == ASR_KIND_READ);
  wire do_write = cmd_evt && (kind_w == ASR_KIND_WRITE);

  // Writes store at once; the host still owes the memory its settle time
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < `ASR_REG_COUNT; i++) begin
        cfg_reg[i] <= (i == int'(`ASR_REG_FILTER)) ? `ASR_FILTER_DEF : `ASR_REG_DEF;
      end
    end else if (do_write) begin
      cfg_reg[cmd_addr] <= cmd_data;                               // [R21]
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Reply sequencing

  asr_reply_t reply_reg;
  asr_reply_t reply_next;
  logic [7:0] resp_reg;

  // A new request beats a select edge in the same cycle, so it is never lost
  always_comb begin
    reply_next = reply_reg;
    if (do_read || do_write) begin
      reply_next = ASR_RPL_ARMED;                                  // [R20] [R21]
    end else begin
      unique case (reply_reg)
        ASR_RPL_NONE: begin
          reply_next = ASR_RPL_NONE;
        end
        ASR_RPL_ARMED: begin
          if (cs_fall) begin
            reply_next = ASR_RPL_SENDING;
          end
        end
        ASR_RPL_SENDING: begin
          if (cs_rise) begin
            reply_next = ASR_RPL_NONE;
          end
        end
        default: begin
          reply_next = ASR_RPL_NONE;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      reply_reg <= ASR_RPL_NONE;
      resp_reg  <= 8'h00;
    end else begin
      reply_reg <= reply_next;
      if (do_read) begin
        resp_reg <= cfg_reg[cmd_addr];                             // [R20]
      end else if (do_write) begin
        resp_reg <= cmd_data;                                      // [R21]
      end
    end
  end

  // Word seen by the link; stable while a frame is in flight
  assign tx_word_w = (reply_reg != ASR_RPL_NONE) ? {resp_reg, 8'h00} : angle_buf_reg;

  //////////////////////////////////////////////////////////////////////////////
  // On-chip angle output

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      angle_out  <= 16'h0000;
      angle_tick <= 1'b0;
    end else begin
      angle_tick <= tick_now;
      if (tick_now) begin
        angle_out <= padded_w;
      end
    end
  end

endmodule : asr_readout

`default_nettype wire

// ### verification/asr_readout_chk.sv
// Concurrent checks on the angle readout ports
`timescale 1ns/100ps
`default_nettype none

module asr_readout_chk #(
  parameter int ANGLE_BITS = 14
) (
  // System clock and reset
  input wire logic        clk,
  input wire logic        rst_b,
  // Front-end angle code
  input wire logic [15:0] fe_angle,
  // Serial link
  input wire logic        spi_sclk,
  input wire logic        spi_cs_b,
  input wire logic        spi_mosi,
  input wire logic        spi_miso,
  input wire logic        spi_miso_oe_b,
  // Smoothed angle
  input wire logic [15:0] angle_out,
  input wire logic        angle_tick
);
  localparam logic [15:0] LOW_MASK = (16'h0001 << (16 - ANGLE_BITS)) - 16'h0001;
  logic [4:0]             rise_cnt_reg;

  ////////////////////////////////////////
  // Rising edges of this frame; saturates so long frames never wrap
  always_ff @(posedge spi_sclk or posedge spi_cs_b) begin
    if (spi_cs_b) begin
      rise_cnt_reg <= 5'h00;
    end else if (rise_cnt_reg != 5'h1f) begin
      rise_cnt_reg <= rise_cnt_reg + 5'h01;
    end
  end

  sequence s_tick_quiet;
    !angle_tick [*8];
  endsequence

  sequence s_first_tick;
    $rose(rst_b) ##[1:26] angle_tick;
  endsequence

  ////////////////////////////////////////
  a_oe_follows_cs: assert property (
    @(posedge clk) disable iff (!rst_b) spi_miso_oe_b == spi_cs_b)
    else $error("miso enable differs from select");
  a_miso_idle_low: assert property (
    @(posedge clk) disable iff (!rst_b) spi_cs_b |-> !spi_miso)
    else $error("miso not low while deselected");
  a_miso_after_word: assert property (
    @(posedge spi_sclk) disable iff (!rst_b)
    (!spi_cs_b && rise_cnt_reg >= 5'h10) |-> !spi_miso)
    else $error("miso not low after sixteen bits");
  a_tick_period: assert property (
    @(posedge clk) disable iff (!rst_b) angle_tick |=> s_tick_quiet ##17 angle_tick)
    else $error("angle update not every 25 cycles");
  a_out_on_tick: assert property (
    @(posedge clk) disable iff (!rst_b) $changed(angle_out) |-> angle_tick)
    else $error("angle changed without update pulse");
  a_pad_zero: assert property (
    @(posedge clk) disable iff (!rst_b) angle_tick |-> (angle_out & LOW_MASK) == 16'h0000)
    else $error("bits below resolution not zero");
  a_first_tick: assert property (
    @(posedge clk) disable iff (!rst_b)
    $rose(rst_b) |-> angle_out == 16'h0000 ##[1:26] angle_tick)
    else $error("no first update after reset");
  // First update still shows the unprimed loop; the seeded value follows one period later
  a_seeded_angle: assert property (
    @(posedge clk) disable iff (!rst_b)
    s_first_tick |-> ##25 (angle_tick && angle_out == (fe_angle & ~LOW_MASK)))
    else $error("second angle differs from steady input");
endmodule : asr_readout_chk

`default_nettype wire

// ### verification/asr_spi_master.sv
// Behavioural four-wire host for the angle readout link
`timescale 1ns/100ps
`default_nettype none

module asr_spi_master #(
  parameter real HALF_NS = 7.5
) (
  // Lines driven by the host
  output var logic spi_sclk,
  output var logic spi_cs_b,
  output var logic spi_mosi,
  // Device data line and its enable
  input wire logic spi_miso,
  input wire logic spi_miso_oe_b
);
  // Pull-down wins when the device lets go of the line
  wire logic miso_w = spi_miso_oe_b ? 1'b0 : spi_miso;

  initial begin
    spi_sclk = 1'b0;
    spi_cs_b = 1'b1;
    spi_mosi = 1'b0;
  end

  ////////////////////////////////////////
  // Clock only moves to its idle level outside frames; gaps are the caller's duty
  task automatic frame(input bit mode3, input int n, input logic [15:0] tx,
                       output logic [15:0] rx);
    rx = 16'h0000;
    spi_sclk = mode3;
    #(HALF_NS);
    spi_cs_b = 1'b0;
    spi_mosi = tx[15];
    #80;
    for (int i = 0; i < n; i++) begin
      if (mode3) begin
        spi_sclk = 1'b0;
        spi_mosi = (i < 16) ? tx[15 - i] : 1'b0;
        #(HALF_NS);
      end
      spi_sclk = 1'b1;
      if (i < 16) rx = {rx[14:0], miso_w};
      #(HALF_NS);
      if (!mode3) begin
        spi_sclk = 1'b0;
        spi_mosi = (i < 15) ? tx[14 - i] : 1'b0;
        #(HALF_NS);
      end
    end
    #25;
    spi_cs_b = 1'b1;
    spi_mosi = 1'b0;
  endtask : frame
endmodule : asr_spi_master

`default_nettype wire

// ### verification/asr_readout_tb_top.sv
// Self-checking bench for the angle readout block
`include "asr_defs.svh"
`timescale 1ns/100ps
`default_nettype none

module asr_readout_tb_top;
  localparam int          AB   = 14;
  localparam logic [15:0] MASK = ~((16'h0001 << (16 - AB)) - 16'h0001);
  logic        clk;
  logic        rst_b;
  logic [15:0] fe_angle;
  wire logic   spi_sclk;
  wire logic   spi_cs_b;
  wire logic   spi_mosi;
  logic        spi_miso;
  logic        spi_miso_oe_b;
  logic [15:0] angle_out;
  logic        angle_tick;
  int          mismatches = 0;
  int          n_checks = 0;
  int          cycles = 0;
  int          seed;
  bit          mode3 = 1'b0;
  logic [15:0] a;
  logic [15:0] z;
  logic [15:0] e;
  logic [15:0] rx;

  asr_readout #(.ANGLE_BITS(AB)) asr_readout_inst (
    .clk(clk), .rst_b(rst_b), .fe_angle(fe_angle), .spi_sclk(spi_sclk),
    .spi_cs_b(spi_cs_b), .spi_mosi(spi_mosi), .spi_miso(spi_miso),
    .spi_miso_oe_b(spi_miso_oe_b), .angle_out(angle_out), .angle_tick(angle_tick));

  asr_spi_master asr_spi_master_inst (
    .spi_sclk(spi_sclk), .spi_cs_b(spi_cs_b), .spi_mosi(spi_mosi),
    .spi_miso(spi_miso), .spi_miso_oe_b(spi_miso_oe_b));

  always #20 clk = ~clk;

  // Whole run is near 1200 cycles; the ceiling leaves ample margin
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      mismatches++;
      stop_test();
    end
  end

  ////////////////////////////////////////
  function automatic logic [15:0] exp_angle(input logic [15:0] ang, input logic [15:0] zero,
                                            input bit rev);
    logic [15:0] d;
    d = ang - zero;
    if (rev) d = 16'h0000 - d;
    return d & MASK;
  endfunction : exp_angle

  task automatic chk_word(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask : chk_word

  task automatic chk_bit(input string what, input logic exp, input logic got);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected %s expected %b seen %b", what, exp, got);
    end
  endtask : chk_bit

  // Modes alternate so both idle levels see every kind of frame
  task automatic xfer(input int n, input logic [15:0] tx, input int gap);
    mode3 = ~mode3;
    asr_spi_master_inst.frame(mode3, n, tx, rx);
    repeat (gap) @(negedge clk);
  endtask : xfer

  task automatic stop_test;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : stop_test

  ////////////////////////////////////////
  initial begin
    seed = 24318;
    clk = 1'b0;
    rst_b = 1'b0;
    fe_angle = 16'h0000;
    for (int it = 0; it < 3; it++) begin
      a = 16'($random(seed));
      z = {8'($random(seed)), 8'h00};
      e = exp_angle(a, 16'h0000, 1'b0);
      @(negedge clk);
      rst_b = 1'b0;
      fe_angle = a;
      repeat (8) @(negedge clk);
      chk_bit("miso in reset", 1'b0, spi_miso);
      chk_bit("oe_b in reset", 1'b1, spi_miso_oe_b);
      rst_b = 1'b1;
      repeat (60) @(negedge clk);
      chk_word("steady angle_out", e, angle_out);
      // Five falling clk edges keep select high past the 150 ns minimum
      xfer(16, 16'h0000, 5);
      chk_word("angle read", e, rx);
      xfer(16, 16'h0000, 20);
      chk_word("repeated read", e, rx);
      xfer(8, 16'h0000, 20);
      chk_word("partial read", {8'h00, e[15:8]}, rx);
      xfer(20, 16'h0000, 20);
      chk_word("long read", e, rx);
      xfer(16, {3'h2, 5'h0e, 8'h00}, 20);
      xfer(16, 16'h0000, 20);
      chk_word("register 0e", {`ASR_FILTER_DEF, 8'h00}, rx);
      xfer(16, 16'h0000, 20);
      chk_word("angle after reply", e, rx);
      // Limitation: memory settle time is not modelled, so the echo need not wait
      xfer(16, {3'h4, 5'h09, 8'h80}, 20);
      xfer(16, {3'h4, 5'h01, z[15:8]}, 20);
      chk_word("direction echo", 16'h8000, rx);
      xfer(16, 16'h0000, 60);
      chk_word("zero echo", z, rx);
      chk_word("adjusted angle_out", exp_angle(a, z, 1'b1), angle_out);
      xfer(16, 16'h0000, 20);
      chk_word("adjusted read", exp_angle(a, z, 1'b1), rx);
      $display("test %0d ended", it);
    end
    stop_test();
  end
endmodule : asr_readout_tb_top

bind asr_readout asr_readout_chk #(.ANGLE_BITS(ANGLE_BITS)) asr_readout_chk_inst (
  .clk(clk), .rst_b(rst_b), .fe_angle(fe_angle), .spi_sclk(spi_sclk),
  .spi_cs_b(spi_cs_b), .spi_mosi(spi_mosi), .spi_miso(spi_miso),
  .spi_miso_oe_b(spi_miso_oe_b), .angle_out(angle_out), .angle_tick(angle_tick));

`default_nettype wire
